// ==== design/rx_capture_udp_packer.sv ====
// capture store, UDP byte packer and storage row feeder with APB settings
// assumes samples and ready inputs synchronous to clk_sys_i
//
// The implementer's own choices: the APB register port and the placing of the registers.
`default_nettype none
module rx_capture_udp_packer #(
  parameter int DEPTH = 1024,
  parameter int PKT_WORDS = 64
) (
  input wire logic clk_sys_i, // 40 MHz
  input wire logic rst_n_i, // sync, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [rx_capture_pkg::APB_AW-1:0] paddr_i, // apb address
  input wire logic [31:0] pwdata_i, // apb write data
  output logic [31:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic smp_valid_i, // sample valid
  input wire rx_capture_pkg::iq_word_t smp_i, // both channels
  output logic udp_valid_o, // payload byte valid
  input wire logic udp_ready_i, // payload byte taken
  output logic [7:0] udp_data_o, // payload byte
  output logic udp_sof_o, // first byte of packet
  output logic udp_eof_o, // last byte of packet
  output rx_capture_pkg::udp_hdr_t udp_hdr_o, // packet addressing
  output logic sd_valid_o, // storage row valid
  input wire logic sd_ready_i, // storage row taken
  output rx_capture_pkg::iq_word_t sd_row_o, // four columns
  output logic [2:0] rate_cur_o, // applied rate code
  output logic recal_o // recalibration pulse
);
  import rx_capture_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;
  localparam int PW = $clog2(PKT_WORDS);

  cap_state_t state_r;
  iq_word_t mem_r [DEPTH];
  logic [AW-1:0] wr_idx_r;
  logic [AW-1:0] rd_idx_r;
  logic [LW-1:0] len_r;
  logic [2:0] byte_cnt_r;
  logic [PW-1:0] pkt_cnt_r;
  logic [63:0] sh_r;
  logic [31:0] prdata_r;
  logic dest_udp_r;
  logic done_r;
  logic iq_listed_r;
  logic [2:0] rate_pend_r;
  logic [2:0] rate_cur_r;
  logic recal_r;
  logic [3:0] name_base_r;
  logic [1:0] name_ext_len_r;
  logic [15:0] name_ext_r;

  // apb decode, zero wait states
  wire setup_w = psel_i && !penable_i;
  wire acc_w = psel_i && penable_i;
  wire sel_ctrl_w = paddr_i == OFS_CTRL;
  wire sel_len_w = paddr_i == OFS_LEN;
  wire sel_rate_w = paddr_i == OFS_RATE;
  wire sel_name_w = paddr_i == OFS_NAME;
  wire sel_stat_w = paddr_i == OFS_STAT;
  wire mapped_w = sel_ctrl_w || sel_len_w || sel_rate_w || sel_name_w || sel_stat_w;
  wire wr_w = acc_w && pwrite_i;
  wire idle_w = state_r == ST_IDLE;
  wire [LW-1:0] len_req_w = pwdata_i[LW-1:0];
  wire len_ok_w = len_req_w[BLOCK_LSB-1:0] == '0 && len_req_w != '0 && pwdata_i[31:LW] == '0
    && len_req_w <= LW'(DEPTH);
  wire rate_ok_w = pwdata_i[2:0] < RATE_NUM && pwdata_i[31:3] == '0;
  wire name_ok_w = pwdata_i[3:0] <= NAME_BASE_MAX && pwdata_i[5:4] <= NAME_EXT_MAX;
  wire bad_wr_w = (sel_len_w && !(len_ok_w && idle_w)) || (sel_rate_w && !rate_ok_w)
    || (sel_name_w && !name_ok_w) || sel_stat_w;
  wire err_w = !mapped_w || (pwrite_i && bad_wr_w);
  wire len_wr_w = wr_w && sel_len_w && len_ok_w && idle_w;
  wire start_w = wr_w && sel_ctrl_w && pwdata_i[CTRL_START] && idle_w;
  wire tog_w = wr_w && sel_ctrl_w && pwdata_i[CTRL_DEST_TOG] && idle_w;
  wire apply_w = wr_w && sel_ctrl_w && pwdata_i[CTRL_RATE_EXIT];
  wire done_clr_w = wr_w && sel_ctrl_w && pwdata_i[CTRL_DONE_CLR];

  // capture and drain handshakes
  wire cap_w = state_r == ST_CAPT && smp_valid_i;
  wire cap_last_w = cap_w && LW'(wr_idx_r) == len_r - LW'(1);
  wire udp_take_w = udp_valid_o && udp_ready_i;
  wire sd_take_w = sd_valid_o && sd_ready_i;
  wire last_word_w = LW'(rd_idx_r) == len_r - LW'(1);
  wire word_end_w = byte_cnt_r == 3'h7;
  wire pkt_end_w = pkt_cnt_r == PW'(PKT_WORDS - 1);
  wire send_fin_w = udp_take_w && word_end_w && last_word_w;
  wire file_fin_w = sd_take_w && last_word_w;
  wire [AW-1:0] rd_next_w = rd_idx_r + AW'(1);
  wire ext_iq_w = name_ext_len_r == NAME_EXT_MAX && name_ext_r == EXT_IQ;
  wire [31:0] stat_w = {28'h0, iq_listed_r, dest_udp_r, done_r, !idle_w};
  wire [31:0] name_rd_w = {name_ext_r, 10'h0, name_ext_len_r, name_base_r};
  wire [31:0] rd_mux_w = sel_len_w ? 32'(len_r)
    : sel_rate_w ? {26'h0, rate_cur_r, rate_pend_r}
    : sel_name_w ? name_rd_w
    : sel_stat_w ? stat_w : 32'h0;

  assign pready_o = 1'b1;
  assign pslverr_o = acc_w && err_w;
  assign prdata_o = prdata_r;
  assign udp_valid_o = state_r == ST_SEND;
  assign udp_data_o = sh_r[7:0];
  assign udp_sof_o = udp_valid_o && byte_cnt_r == 3'h0 && pkt_cnt_r == '0;
  assign udp_eof_o = udp_valid_o && word_end_w && (pkt_end_w || last_word_w);
  assign udp_hdr_o = '{src_ip: SRC_IP, dst_ip: DST_IP, dst_port: DST_PORT, bcast: 1'b1};
  assign sd_valid_o = state_r == ST_FILE;
  assign sd_row_o = iq_word_t'(sh_r);
  assign rate_cur_o = rate_cur_r;
  assign recal_o = recal_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (setup_w)
    begin
      prdata_r <= rd_mux_w;
    end
    if (!rst_n_i)
    begin
      prdata_r <= 32'h0;
    end
  end

  // sample store; a flat word keeps the 63:48 .. 15:0 layout
  always_ff @(posedge clk_sys_i)
  begin
    if (cap_w)
    begin
      mem_r[wr_idx_r] <= smp_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      wr_idx_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          wr_idx_r <= '0;
          if (start_w)
          begin
            state_r <= ST_CAPT;
          end
        end
        ST_CAPT:
        begin
          if (cap_w)
          begin
            wr_idx_r <= wr_idx_r + AW'(1);
          end
          if (cap_last_w)
          begin
            state_r <= dest_udp_r ? ST_SEND : ST_FILE;
          end
        end
        ST_SEND:
        begin
          if (send_fin_w)
          begin
            state_r <= ST_IDLE;
          end
        end
        ST_FILE:
        begin
          if (file_fin_w)
          begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // drain pointer and byte shifter; the first word is loaded as capture ends
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rd_idx_r <= '0;
      byte_cnt_r <= 3'h0;
      pkt_cnt_r <= '0;
      sh_r <= 64'h0;
    end
    else if (cap_last_w)
    begin
      rd_idx_r <= '0;
      byte_cnt_r <= 3'h0;
      pkt_cnt_r <= '0;
      sh_r <= (wr_idx_r == '0) ? smp_i : mem_r[0];
    end
    else if (udp_take_w)
    begin
      byte_cnt_r <= byte_cnt_r + 3'h1;
      sh_r <= {8'h0, sh_r[63:8]};
      if (word_end_w)
      begin
        rd_idx_r <= rd_next_w;
        sh_r <= mem_r[rd_next_w];
        pkt_cnt_r <= pkt_end_w ? '0 : pkt_cnt_r + PW'(1);
      end
    end
    else if (sd_take_w)
    begin
      rd_idx_r <= rd_next_w;
      sh_r <= mem_r[rd_next_w];
    end
  end

  // settings and status
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      len_r <= LW'(BLOCK_SAMPLES);
      dest_udp_r <= 1'b0;
      done_r <= 1'b0;
      iq_listed_r <= 1'b0;
      name_base_r <= 4'h0;
      name_ext_len_r <= 2'h0;
      name_ext_r <= 16'h0;
    end
    else
    begin
      if (len_wr_w)
      begin
        len_r <= len_req_w;
      end
      if (tog_w)
      begin
        dest_udp_r <= !dest_udp_r;
      end
      if (wr_w && sel_name_w && name_ok_w)
      begin
        name_base_r <= pwdata_i[3:0];
        name_ext_len_r <= pwdata_i[5:4];
        name_ext_r <= pwdata_i[31:16];
      end
      // set wins over software clear
      if (send_fin_w || file_fin_w)
      begin
        done_r <= 1'b1;
      end
      else if (done_clr_w)
      begin
        done_r <= 1'b0;
      end
      if (file_fin_w && ext_iq_w)
      begin
        iq_listed_r <= 1'b1;
      end
    end
  end

  // rate: selection touches pending only, exit applies it
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rate_pend_r <= RATE_RST;
      rate_cur_r <= RATE_RST;
      recal_r <= 1'b0;
    end
    else
    begin
      recal_r <= 1'b0;
      if (wr_w && sel_rate_w && rate_ok_w)
      begin
        rate_pend_r <= pwdata_i[2:0];
      end
      if (apply_w)
      begin
        rate_cur_r <= rate_pend_r;
        recal_r <= rate_pend_r != rate_cur_r;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  chk_len_blocks: assert property (len_r[BLOCK_LSB-1:0] == '0 && len_r != '0)
    else $error("capture length not a block multiple");
  chk_cap_count: assert property ($rose(udp_valid_o) |-> $past(LW'(wr_idx_r)) == len_r - LW'(1))
    else $error("capture ended at wrong count");
  chk_dest_toggle: assert property (tog_w |=> dest_udp_r != $past(dest_udp_r))
    else $error("destination did not flip");
  chk_send_after: assert property (udp_valid_o |-> !sd_valid_o && $past(state_r) != ST_IDLE)
    else $error("udp data before capture end");
  chk_udp_header: assert property (udp_hdr_o.bcast && udp_hdr_o.src_ip == 32'hC0A863C8
    && udp_hdr_o.dst_ip == 32'hFFE1E1E1 && udp_hdr_o.dst_port == 16'h04D2)
    else $error("udp addressing wrong");
  chk_lsb_first: assert property (udp_take_w && byte_cnt_r == 3'h0 && !word_end_w
    |=> udp_data_o == $past(sh_r[15:8]))
    else $error("payload byte order wrong");
  chk_word_boundary: assert property (udp_take_w && udp_eof_o |=> (!udp_valid_o || udp_sof_o) && byte_cnt_r == 3'h0)
    else $error("packet split a word");
  // reset also moves the applied rate; the edge after release must not count as a change
  chk_rate_apply: assert property ($past(rst_n_i) && rate_cur_r != $past(rate_cur_r) |-> $past(apply_w))
    else $error("rate changed without exit");
  chk_recal_pulse: assert property (apply_w && rate_pend_r != rate_cur_r |=> recal_o ##1 !recal_o)
    else $error("recalibration not triggered");
  chk_iq_listed: assert property ($rose(iq_listed_r) |-> $past(file_fin_w) && $past(ext_iq_w))
    else $error("listed without iq storage capture");
endmodule : rx_capture_udp_packer
`default_nettype wire

// ==== design/rx_capture_pkg.sv ====
// constants and types of the receive capture packer
// assumes one 40 MHz clock, APB register access, UDP/IP stack downstream
`default_nettype none
package rx_capture_pkg;
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LEN = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_NAME = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_DEST_TOG = 1;
  localparam int CTRL_RATE_EXIT = 2;
  localparam int CTRL_DONE_CLR = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_DEST_UDP = 2;
  localparam int STAT_IQ_LISTED = 3;
  localparam int BLOCK_LSB = 9;
  localparam int BLOCK_SAMPLES = 512;
  // rate codes: 0=1.92 1=3.84 2=7.68 3=15.36 4=30.72 5=61.44 mega_samples_per_second
  localparam logic [2:0] RATE_NUM = 3'h6;
  localparam logic [2:0] RATE_RST = 3'h0;
  localparam logic [3:0] NAME_BASE_MAX = 4'h9;
  localparam logic [1:0] NAME_EXT_MAX = 2'h2;
  localparam logic [15:0] EXT_IQ = 16'h6971;
  localparam logic [31:0] SRC_IP = 32'hC0A863C8;
  localparam logic [31:0] DST_IP = 32'hFFE1E1E1;
  localparam logic [15:0] DST_PORT = 16'h04D2;

  typedef struct packed {
    logic signed [15:0] first_i;
    logic signed [15:0] first_q;
    logic signed [15:0] second_i;
    logic signed [15:0] second_q;
  } iq_word_t;

  typedef struct packed {
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [15:0] dst_port;
    logic bcast;
  } udp_hdr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAPT = 2'b01,
    ST_SEND = 2'b10,
    ST_FILE = 2'b11
  } cap_state_t;
endpackage : rx_capture_pkg
`default_nettype wire

// ==== tb/udp_host_model.sv ====
// host side: takes broadcast payload bytes and keeps them for the bench
// assumes valid holds the byte until taken
`default_nettype none
module udp_host_model (
  input wire logic clk_i, // bench clock
  input wire logic valid_i, // byte offered
  input wire logic [7:0] data_i, // payload byte
  input wire logic sof_i, // packet start
  input wire logic eof_i, // packet end
  output logic ready_o // byte taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_r = 3'h0;
  logic [7:0] data_q[$];
  logic [1:0] flag_q[$];
  // stalls two cycles in eight so held bytes get exercised
  assign ready_o = cnt_r[2:1] != 2'b11;
  always @(posedge clk_i)
  begin
    cnt_r <= cnt_r + 3'h1;
    if (valid_i && ready_o)
    begin
      data_q.push_back(data_i);
      flag_q.push_back({sof_i, eof_i});
    end
  end
endmodule : udp_host_model
`default_nettype wire

// ==== tb/tb.sv ====
// bench for the capture packer: APB settings, UDP and storage captures
// assumes PKT_WORDS=4, LEN=512
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rx_capture_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic er; logic [31:0] rd;} row_t;
  logic clk = 1'b0, rst_n, psel, pen, pwr, pready, pslverr, sval, uval, urdy, usof, ueof, sdv, sdr, recal;
  logic [7:0] paddr, udata;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] rcur;
  iq_word_t smp, row;
  udp_hdr_t hdr;
  iq_word_t rows_q[$];
  logic er;
  logic [63:0] w;
  int err_count = 0, comparisons = 0, recal_n = 0, exp_recal = 0, cur, i;
  row_t tab[15] = '{
    '{0, OFS_LEN, 0, 0, 32'h200}, '{1, OFS_LEN, 32'h300, 1, 0}, '{1, OFS_LEN, 0, 1, 0},
    '{1, OFS_LEN, 32'h800, 1, 0}, '{1, OFS_LEN, 32'h400, 0, 0}, '{0, OFS_LEN, 0, 0, 32'h400},
    '{1, OFS_LEN, 32'h200, 0, 0}, '{0, OFS_STAT, 0, 0, 0}, '{1, OFS_STAT, 32'hF, 1, 0},
    '{0, 8'h14, 0, 1, 0}, '{0, OFS_CTRL, 0, 0, 0}, '{1, OFS_RATE, 32'h6, 1, 0},
    '{1, OFS_NAME, 32'hA, 1, 0}, '{1, OFS_NAME, 32'h39, 1, 0}, '{1, OFS_NAME, 32'h69710029, 0, 0}};
  rx_capture_udp_packer #(.DEPTH(1024), .PKT_WORDS(4)) dut_u (.clk_sys_i(clk), .rst_n_i(rst_n),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .smp_valid_i(sval), .smp_i(smp),
    .udp_valid_o(uval), .udp_ready_i(urdy), .udp_data_o(udata), .udp_sof_o(usof), .udp_eof_o(ueof),
    .udp_hdr_o(hdr), .sd_valid_o(sdv), .sd_ready_i(sdr), .sd_row_o(row), .rate_cur_o(rcur),
    .recal_o(recal));
  udp_host_model host_u (.clk_i(clk), .valid_i(uval), .data_i(udata), .sof_i(usof), .eof_i(ueof),
    .ready_o(urdy));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    sdr <= ~sdr;
    if (recal === 1'b1) recal_n++;
    if (sdv === 1'b1 && sdr === 1'b1) rows_q.push_back(row);
  end
  task cmp(input string nm, input logic [80:0] e, input logic [80:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no wait-state count assumed; only the watchdog ends a stuck wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic iq_word_t mkw(input int k);
    logic [15:0] v;
    v = 16'(k);
    return {v ^ 16'h8000, ~v, v, 16'h7FFF - v};
  endfunction : mkw
  task cap;
    apb(1, OFS_CTRL, 32'h1);
    for (i = 0; i < 512; i++)
    begin
      sval <= 1'b1; smp <= mkw(i);
      @(negedge clk);
      cmp("early out", 0, uval | sdv);
      @(posedge clk);
    end
    sval <= 1'b0;
    // drain is over when neither output offers data; queues from earlier captures do not count
    @(posedge clk);
    while (uval === 1'b1 || sdv === 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask : cap
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial
  begin
    {rst_n, psel, pen, pwr, sval, sdr, paddr, pwdata, smp} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (tab[k])
    begin
      apb(tab[k].w, tab[k].a, tab[k].d);
      cmp("slverr", tab[k].er, er);
      if (!tab[k].w) cmp("rdata", tab[k].rd, rd);
    end
    $display("register table done");
    cur = 0;
    for (i = 0; i < 6; i++)
    begin
      apb(1, OFS_RATE, i);
      apb(0, OFS_RATE, 0);
      cmp("rate reg", {cur[2:0], i[2:0]}, rd[5:0]);
      apb(1, OFS_CTRL, 32'h4);
      repeat (3) @(posedge clk);
      if (i != cur) exp_recal++;
      cur = i;
      cmp("rate cur", cur[2:0], rcur);
      cmp("recal", exp_recal, recal_n);
    end
    $display("rate test done");
    apb(1, OFS_CTRL, 32'h2);
    apb(0, OFS_STAT, 0);
    cmp("dest udp", 32'h4, rd);
    cap();
    cmp("hdr", {32'hC0A863C8, 32'hFFE1E1E1, 16'h04D2, 1'b1}, hdr);
    cmp("bytes", 4096, host_u.data_q.size());
    for (i = 0; i < 4096; i++)
    begin
      w = mkw(i / 8);
      cmp("byte", w[8 * (i % 8) +: 8], host_u.data_q[i]);
      cmp("sof eof", {i % 32 == 0, i % 32 == 31}, host_u.flag_q[i]);
    end
    apb(0, OFS_STAT, 0);
    cmp("udp stat", 32'h6, rd);
    $display("udp capture done");
    apb(1, OFS_CTRL, 32'hA);
    cap();
    cmp("rows", 512, rows_q.size());
    for (i = 0; i < 512; i++) cmp("row", mkw(i), rows_q[i]);
    apb(0, OFS_STAT, 0);
    cmp("file stat", 32'hA, rd);
    $display("storage capture done");
    apb(1, OFS_CTRL, 32'h1);
    apb(1, OFS_LEN, 32'h400);
    cmp("busy len", 1, er);
    apb(0, OFS_STAT, 0);
    cmp("busy stat", 32'hB, rd);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, OFS_STAT, 0);
    cmp("reset stat", 32'h0, rd);
    apb(0, OFS_RATE, 0);
    cmp("reset rate", 32'h0, rd);
    apb(0, OFS_LEN, 0);
    cmp("reset len", 32'h200, rd);
    $display("reset test done");
    close_out();
  end
endmodule : tb
`default_nettype wire
